/* File: scrub_sefi_defs.svh */
// Constants for the scrubber and SEFI monitor
`ifndef SCRUB_SEFI_DEFS_SVH
`define SCRUB_SEFI_DEFS_SVH
`define LANES 12
`define LANE_CW 6
`define ADDR_W 16
`define DATA_W 64
`define ADDR_CW 8
`define RATE_W 16
`define ACCEL_PERIOD 16'h0004
`endif

/* File: sefi_pkg.sv */
// Types shared by the scrubber and SEFI monitor
package sefi_pkg;
  typedef enum logic [4:0] {
    MEM_IDLE = 5'h01,
    MEM_INIT_WR = 5'h02,
    MEM_VER_RD = 5'h04,
    MEM_SCR_RD = 5'h08,
    MEM_SCR_WB = 5'h10
  } mem_state_type;
  typedef enum logic [3:0] {
    SEFI_IDLE = 4'h1,
    SEFI_RECAL = 4'h2,
    SEFI_ACCEL = 4'h4,
    SEFI_WATCH = 4'h8
  } sefi_state_type;
  typedef enum logic [1:0] {
    LANE_NORMAL = 2'h0,
    LANE_RECOVER = 2'h1,
    LANE_HEALED = 2'h2,
    LANE_PERM = 2'h3
  } lane_state_type;
endpackage

/* File: lane_err_counters.sv */
// Byte lane error counters with watermark and SEFI detection
`timescale 1ns/1ps
`include "scrub_sefi_defs.svh"
module lane_err_counters #(
  parameter int LANES = `LANES,
  parameter int CW = `LANE_CW
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inc_valid,
  input wire logic [LANES-1:0] inc_lanes,
  output logic [LANES*CW-1:0] lane_cnt,
  output logic [CW-1:0] watermark,
  output logic [LANES-1:0] detect
);
  logic [CW-1:0] cnt_r [LANES];
  logic [CW-1:0] cnt_nxt [LANES];
  logic [LANES-1:0] wm_eq;
  logic [LANES-1:0] detect_r;
  logic [CW-1:0] wm_r;

  // ==========================================
  // Per-lane wrapping counters
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : lane_g
      assign cnt_nxt[g] = cnt_r[g] + 1'b1;
      assign wm_eq[g] = (cnt_r[g] == wm_r);
      assign lane_cnt[g*CW +: CW] = cnt_r[g];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cnt_r[g] <= '0;
          detect_r[g] <= 1'b0;
        end else begin
          detect_r[g] <= 1'b0;
          if (inc_valid && inc_lanes[g]) begin
            cnt_r[g] <= cnt_nxt[g];
            // Wrapped round onto the slowest lane: 64 ahead of it
            detect_r[g] <= (cnt_nxt[g] == wm_r);
          end
        end
      end
      lane_inc_a: assert property (@(posedge core_clk) disable iff (rst)
        (inc_valid && inc_lanes[g]) |=> cnt_r[g] == $past(cnt_r[g]) + 1'b1)
        else $error("lane counter missed an increment");
      detect_a: assert property (@(posedge core_clk) disable iff (rst)
        detect_r[g] |-> cnt_r[g] == $past(wm_r) && $past(cnt_r[g] - wm_r) == 6'h3f)
        else $error("detection fired without wrap onto watermark");
    end
  endgenerate

  // ==========================================
  // Watermark follows the slowest lane
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wm_r <= '0;
    end else if (!(|wm_eq)) begin
      wm_r <= wm_r + 1'b1;
    end
  end

  assign watermark = wm_r;
  assign detect = detect_r;

  wm_track_a: assert property (@(posedge core_clk) disable iff (rst)
    !(|wm_eq) |=> wm_r == $past(wm_r) + 1'b1)
    else $error("watermark did not advance");
endmodule

/* File: scrub_sefi_error_monitor.sv */
// Memory init, scrubber, error statistics and SEFI handling
// How it works
// - With ECC on, init writes all memory with a pattern or each address.
// - Optional verify pass reads init contents back and checks them.
// - Scrubber sweeps memory at a set rate, writes back corrected words.
// - Lane and address counters change only on scrubber-found correctable errors.
// - Twelve wrapping lane counters count scrubber correctable errors per lane.
// - Watermark starts at zero, steps when equal to no lane counter.
// - A lane 64 ahead of the watermark, wrapping onto it, is detected.
// - Recovery can be disabled; detection then only flags lanes.
// - On detection ask back-end for recalibration and mode rewrite, wait.
// - Then scrub whole memory at accelerated rate, then back to normal.
// - A clean normal pass afterwards marks the lane healed.
// - Detection again during that pass marks lane permanent, pulses interrupt.
// - Optionally a permanent lane has its output drivers disabled.
// - Permanent lanes keep counting and may later become healed.
// - PHY read-failure sideband starts SEFI handling for that lane.
// - A PHY read failure pulses a dedicated interrupt.
// - One saturating signed counter per address bit.
// - Counter decrements when address bit is 0, increments when 1.
// - An uncorrectable read cancels the write-back, memory stays untouched.
`timescale 1ns/1ps
`include "scrub_sefi_defs.svh"
module scrub_sefi_error_monitor #(
  parameter int LANES = `LANES,
  parameter int AW = `ADDR_W,
  parameter int DW = `DATA_W,
  parameter int CW = `ADDR_CW,
  parameter int RW = `RATE_W,
  parameter logic [RW-1:0] ACCEL_PERIOD = `ACCEL_PERIOD
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ecc_en,
  input wire logic init_start,
  input wire logic init_use_addr,
  input wire logic init_verify,
  input wire logic [DW-1:0] init_pattern,
  input wire logic [AW-1:0] end_addr,
  input wire logic scrub_en,
  input wire logic [RW-1:0] scrub_period,
  input wire logic recovery_en,
  input wire logic drv_off_en,
  input wire logic sefi_flag_clr,
  input wire logic [LANES-1:0] phy_lane_fail,
  input wire logic recal_done,
  input wire logic mem_ack,
  input wire logic [DW-1:0] mem_rdata,
  input wire logic [LANES-1:0] mem_ce_lanes,
  input wire logic mem_ue,
  output logic mem_req,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  output logic init_busy,
  output logic init_done,
  output logic init_fail,
  output logic recal_req,
  output logic mode_rewrite_req,
  output logic accel_active,
  output logic scrub_pass_done,
  output logic [LANES-1:0] sefi_seen,
  output logic [2*LANES-1:0] lane_state,
  output logic [LANES-1:0] lane_drv_off,
  output logic perm_sefi_irq,
  output logic phy_err_irq,
  output logic [LANES*`LANE_CW-1:0] lane_cnt,
  output logic [`LANE_CW-1:0] watermark,
  output logic [AW*CW-1:0] addr_err_cnt
);
  localparam int LIW = $clog2(LANES);
  sefi_pkg::mem_state_type mem_st_r;
  sefi_pkg::sefi_state_type sefi_st_r;
  sefi_pkg::lane_state_type lane_st_r [LANES];
  logic mem_req_r, mem_we_r, init_busy_r, init_done_r, init_fail_r;
  logic [AW-1:0] mem_addr_r, init_addr_r, scrub_addr_r, ce_addr_r;
  logic [AW-1:0] init_addr_nxt, scrub_addr_nxt;
  logic [DW-1:0] mem_wdata_r;
  logic pass_done_r, restart_pend_r, scrub_ce_r, tick_pend_r;
  logic [LANES-1:0] ce_lanes_r;
  logic [RW-1:0] rate_cnt_r, period;
  logic init_go, scrub_start;
  logic [LANES-1:0] phy_s1_r, phy_s2_r, phy_s3_r, phy_rise;
  logic [LANES-1:0] detect, ev, elig, sefi_seen_r, drv_off_r, hit_r;
  logic phy_irq_r, perm_irq_r, recal_req_r, accel_r, accel_go_r;
  logic [LIW-1:0] sefi_lane_r, pick_idx;
  logic pick_valid;

  function automatic logic [DW-1:0] fill_word(input logic [AW-1:0] a);
    return init_use_addr ? DW'(a) : init_pattern;
  endfunction

  // ==========================================
  // PHY sideband synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phy_s1_r <= '0;
      phy_s2_r <= '0;
      phy_s3_r <= '0;
      phy_irq_r <= 1'b0;
    end else begin
      phy_s1_r <= phy_lane_fail;
      phy_s2_r <= phy_s1_r;
      phy_s3_r <= phy_s2_r;
      phy_irq_r <= |phy_rise;
    end
  end
  assign phy_rise = phy_s2_r & ~phy_s3_r;

  // ==========================================
  // Scrub rate divider
  assign period = accel_r ? ACCEL_PERIOD : scrub_period;
  assign init_go = init_start && ecc_en;
  assign scrub_start = (mem_st_r == sefi_pkg::MEM_IDLE) && !init_go && tick_pend_r && scrub_en;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rate_cnt_r <= '0;
      tick_pend_r <= 1'b0;
    end else begin
      if (scrub_start) tick_pend_r <= 1'b0;
      if (!scrub_en) begin
        rate_cnt_r <= '0;
      end else if (rate_cnt_r >= period) begin
        rate_cnt_r <= '0;
        tick_pend_r <= 1'b1;
      end else begin
        rate_cnt_r <= rate_cnt_r + 1'b1;
      end
    end
  end

  // ==========================================
  // Memory access sequencer
  assign init_addr_nxt = init_addr_r + 1'b1;
  assign scrub_addr_nxt = (scrub_addr_r == end_addr) ? '0 : scrub_addr_r + 1'b1;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_st_r <= sefi_pkg::MEM_IDLE;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= '0;
      init_addr_r <= '0;
      init_busy_r <= 1'b0;
      init_done_r <= 1'b0;
      init_fail_r <= 1'b0;
      scrub_addr_r <= '0;
      pass_done_r <= 1'b0;
      restart_pend_r <= 1'b0;
      scrub_ce_r <= 1'b0;
      ce_lanes_r <= '0;
      ce_addr_r <= '0;
    end else begin
      pass_done_r <= 1'b0;
      scrub_ce_r <= 1'b0;
      case (mem_st_r)
        sefi_pkg::MEM_IDLE: begin
          if (init_go) begin
            init_busy_r <= 1'b1;
            init_done_r <= 1'b0;
            init_fail_r <= 1'b0;
            init_addr_r <= '0;
            mem_addr_r <= '0;
            mem_wdata_r <= fill_word('0);
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b1;
            mem_st_r <= sefi_pkg::MEM_INIT_WR;
          end else if (scrub_start) begin
            // Accelerated run starts from zero to cover the whole range
            mem_addr_r <= restart_pend_r ? '0 : scrub_addr_r;
            scrub_addr_r <= restart_pend_r ? '0 : scrub_addr_r;
            restart_pend_r <= 1'b0;
            mem_req_r <= 1'b1;
            mem_we_r <= 1'b0;
            mem_st_r <= sefi_pkg::MEM_SCR_RD;
          end
        end
        sefi_pkg::MEM_INIT_WR: if (mem_ack) begin
          if (init_addr_r == end_addr) begin
            init_addr_r <= '0;
            mem_addr_r <= '0;
            mem_we_r <= 1'b0;
            mem_req_r <= init_verify;
            init_busy_r <= init_verify;
            init_done_r <= !init_verify;
            mem_st_r <= init_verify ? sefi_pkg::MEM_VER_RD : sefi_pkg::MEM_IDLE;
          end else begin
            init_addr_r <= init_addr_nxt;
            mem_addr_r <= init_addr_nxt;
            mem_wdata_r <= fill_word(init_addr_nxt);
          end
        end
        sefi_pkg::MEM_VER_RD: if (mem_ack) begin
          if (mem_ue || mem_rdata != fill_word(init_addr_r)) init_fail_r <= 1'b1;
          if (init_addr_r == end_addr) begin
            mem_req_r <= 1'b0;
            init_busy_r <= 1'b0;
            init_done_r <= 1'b1;
            mem_st_r <= sefi_pkg::MEM_IDLE;
          end else begin
            init_addr_r <= init_addr_nxt;
            mem_addr_r <= init_addr_nxt;
          end
        end
        sefi_pkg::MEM_SCR_RD: if (mem_ack) begin
          // Lanes of an uncorrectable word are no trustworthy statistics
          scrub_ce_r <= ecc_en && (|mem_ce_lanes) && !mem_ue;
          ce_lanes_r <= mem_ce_lanes;
          ce_addr_r <= scrub_addr_r;
          if ((|mem_ce_lanes) && !mem_ue) begin
            mem_we_r <= 1'b1;
            mem_wdata_r <= mem_rdata;
            mem_st_r <= sefi_pkg::MEM_SCR_WB;
          end else begin
            // Clean or uncorrectable word is left as found
            mem_req_r <= 1'b0;
            scrub_addr_r <= scrub_addr_nxt;
            pass_done_r <= (scrub_addr_r == end_addr) && !restart_pend_r;
            mem_st_r <= sefi_pkg::MEM_IDLE;
          end
        end
        sefi_pkg::MEM_SCR_WB: if (mem_ack) begin
          mem_req_r <= 1'b0;
          mem_we_r <= 1'b0;
          scrub_addr_r <= scrub_addr_nxt;
          pass_done_r <= (scrub_addr_r == end_addr) && !restart_pend_r;
          mem_st_r <= sefi_pkg::MEM_IDLE;
        end
        default: mem_st_r <= sefi_pkg::MEM_IDLE;
      endcase
      if (accel_go_r) restart_pend_r <= 1'b1;
    end
  end

  // ==========================================
  // Lane and address error statistics
  lane_err_counters #(.LANES(LANES), .CW(`LANE_CW)) lane_ctr_u (
    .core_clk(core_clk),
    .rst(rst),
    .inc_valid(scrub_ce_r),
    .inc_lanes(ce_lanes_r),
    .lane_cnt(lane_cnt),
    .watermark(watermark),
    .detect(detect)
  );

  genvar g;
  generate
    for (g = 0; g < AW; g++) begin : abit_g
      logic signed [CW-1:0] acnt_r;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          acnt_r <= '0;
        end else if (scrub_ce_r) begin
          if (ce_addr_r[g]) begin
            if (acnt_r != {1'b0, {(CW-1){1'b1}}}) acnt_r <= acnt_r + 1'b1;
          end else if (acnt_r != {1'b1, {(CW-1){1'b0}}}) begin
            acnt_r <= acnt_r - 1'b1;
          end
        end
      end
      assign addr_err_cnt[g*CW +: CW] = acnt_r;
    end
    for (g = 0; g < LANES; g++) begin : lane_g
      assign elig[g] = ev[g] && (lane_st_r[g] != sefi_pkg::LANE_RECOVER) && (lane_st_r[g] != sefi_pkg::LANE_PERM);
      assign lane_state[2*g +: 2] = lane_st_r[g];
    end
  endgenerate

  // ==========================================
  // SEFI handler
  assign ev = detect | phy_rise;
  always_comb begin
    pick_valid = 1'b0;
    pick_idx = '0;
    for (int i = LANES - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick_valid = 1'b1;
        pick_idx = LIW'(i);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sefi_seen_r <= '0;
    end else begin
      // New detection wins over a clear in the same cycle
      sefi_seen_r <= (sefi_seen_r & ~{LANES{sefi_flag_clr}}) | ev;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sefi_st_r <= sefi_pkg::SEFI_IDLE;
      sefi_lane_r <= '0;
      recal_req_r <= 1'b0;
      accel_r <= 1'b0;
      accel_go_r <= 1'b0;
      perm_irq_r <= 1'b0;
      drv_off_r <= '0;
      hit_r <= '0;
      for (int i = 0; i < LANES; i++) lane_st_r[i] <= sefi_pkg::LANE_NORMAL;
    end else begin
      accel_go_r <= 1'b0;
      perm_irq_r <= 1'b0;
      for (int i = 0; i < LANES; i++) begin
        if (lane_st_r[i] == sefi_pkg::LANE_PERM) begin
          if (ev[i]) begin
            hit_r[i] <= 1'b1;
          end else if (pass_done_r) begin
            hit_r[i] <= 1'b0;
            if (!hit_r[i]) begin
              lane_st_r[i] <= sefi_pkg::LANE_HEALED;
              drv_off_r[i] <= 1'b0;
            end
          end
        end
      end
      case (sefi_st_r)
        sefi_pkg::SEFI_IDLE: if (recovery_en && pick_valid) begin
          sefi_lane_r <= pick_idx;
          lane_st_r[pick_idx] <= sefi_pkg::LANE_RECOVER;
          recal_req_r <= 1'b1;
          sefi_st_r <= sefi_pkg::SEFI_RECAL;
        end
        sefi_pkg::SEFI_RECAL: if (recal_done) begin
          recal_req_r <= 1'b0;
          accel_r <= 1'b1;
          accel_go_r <= 1'b1;
          sefi_st_r <= sefi_pkg::SEFI_ACCEL;
        end
        sefi_pkg::SEFI_ACCEL: if (pass_done_r) begin
          accel_r <= 1'b0;
          sefi_st_r <= sefi_pkg::SEFI_WATCH;
        end
        sefi_pkg::SEFI_WATCH: begin
          if (ev[sefi_lane_r]) begin
            lane_st_r[sefi_lane_r] <= sefi_pkg::LANE_PERM;
            hit_r[sefi_lane_r] <= 1'b0;
            drv_off_r[sefi_lane_r] <= drv_off_en;
            perm_irq_r <= 1'b1;
            sefi_st_r <= sefi_pkg::SEFI_IDLE;
          end else if (pass_done_r) begin
            lane_st_r[sefi_lane_r] <= sefi_pkg::LANE_HEALED;
            sefi_st_r <= sefi_pkg::SEFI_IDLE;
          end
        end
        default: sefi_st_r <= sefi_pkg::SEFI_IDLE;
      endcase
    end
  end

  // ==========================================
  // Outputs
  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign init_busy = init_busy_r;
  assign init_done = init_done_r;
  assign init_fail = init_fail_r;
  assign recal_req = recal_req_r;
  assign mode_rewrite_req = recal_req_r;
  assign accel_active = accel_r;
  assign scrub_pass_done = pass_done_r;
  assign sefi_seen = sefi_seen_r;
  assign lane_drv_off = drv_off_r;
  assign perm_sefi_irq = perm_irq_r;
  assign phy_err_irq = phy_irq_r;

  // ==========================================
  // Checks
  init_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    (mem_st_r == sefi_pkg::MEM_IDLE && init_start && !ecc_en) |=> mem_st_r != sefi_pkg::MEM_INIT_WR)
    else $error("init started without ECC");
  verify_follow_a: assert property (@(posedge core_clk) disable iff (rst)
    (mem_st_r == sefi_pkg::MEM_INIT_WR && mem_ack && init_addr_r == end_addr && init_verify)
    |=> mem_st_r == sefi_pkg::MEM_VER_RD && mem_req_r && !mem_we_r && mem_addr_r == '0)
    else $error("verify read did not follow init");
  writeback_a: assert property (@(posedge core_clk) disable iff (rst)
    (mem_st_r == sefi_pkg::MEM_SCR_RD && mem_ack && (|mem_ce_lanes) && !mem_ue)
    |=> mem_req_r && mem_we_r && mem_addr_r == $past(mem_addr_r) && mem_wdata_r == $past(mem_rdata))
    else $error("corrected word not written back");
  no_wb_ue_a: assert property (@(posedge core_clk) disable iff (rst)
    (mem_st_r == sefi_pkg::MEM_SCR_RD && mem_ack && mem_ue) |=> !mem_req_r ##1 mem_st_r != sefi_pkg::MEM_SCR_WB)
    else $error("write-back after uncorrectable read");
  scrub_only_a: assert property (@(posedge core_clk) disable iff (rst)
    scrub_ce_r |-> $past(mem_st_r == sefi_pkg::MEM_SCR_RD && mem_ack))
    else $error("counters fed by a non-scrub access");
  passive_a: assert property (@(posedge core_clk) disable iff (rst)
    (sefi_st_r == sefi_pkg::SEFI_IDLE && !recovery_en) |=> sefi_st_r == sefi_pkg::SEFI_IDLE && !recal_req_r)
    else $error("recovery acted while disabled");
  recal_start_a: assert property (@(posedge core_clk) disable iff (rst)
    (sefi_st_r == sefi_pkg::SEFI_IDLE && recovery_en && pick_valid)
    |=> recal_req_r && sefi_st_r == sefi_pkg::SEFI_RECAL
    && lane_st_r[$past(pick_idx)] == sefi_pkg::LANE_RECOVER)
    else $error("recalibration not requested");
  accel_rate_a: assert property (@(posedge core_clk) disable iff (rst)
    sefi_st_r == sefi_pkg::SEFI_ACCEL |-> accel_r && period == ACCEL_PERIOD)
    else $error("accelerated rate not in use");
  perm_a: assert property (@(posedge core_clk) disable iff (rst)
    (sefi_st_r == sefi_pkg::SEFI_WATCH && ev[sefi_lane_r])
    |=> perm_irq_r && lane_st_r[$past(sefi_lane_r)] == sefi_pkg::LANE_PERM ##1 !perm_irq_r)
    else $error("permanent SEFI not flagged");
  phy_irq_a: assert property (@(posedge core_clk) disable iff (rst)
    (|phy_rise) |=> phy_irq_r)
    else $error("PHY failure interrupt missing");
  heal_c: cover property (@(posedge core_clk) disable iff (rst)
    sefi_st_r == sefi_pkg::SEFI_WATCH && pass_done_r && !ev[sefi_lane_r]);
  perm_c: cover property (@(posedge core_clk) disable iff (rst) perm_irq_r);
  wb_c: cover property (@(posedge core_clk) disable iff (rst) mem_st_r == sefi_pkg::MEM_SCR_WB && mem_ack);
  verify_c: cover property (@(posedge core_clk) disable iff (rst) init_done_r && !init_fail_r);
endmodule

/* File: mem_backend_model.sv */
// Back-end stand-in: small word store, error injection and recalibration
`timescale 1ns/1ps
module mem_backend_model #(
  parameter int LANES = 12,
  parameter int AW = 16,
  parameter int DW = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [DW-1:0] mem_wdata,
  input wire logic recal_req,
  input wire logic [LANES-1:0] inj_ce,
  input wire logic inj_ue,
  input wire logic [AW-1:0] inj_addr,
  input wire logic hold_recal,
  output logic mem_ack,
  output logic [DW-1:0] mem_rdata,
  output logic [LANES-1:0] mem_ce_lanes,
  output logic mem_ue,
  output logic recal_done
);
  logic [DW-1:0] mem [0:15];
  logic busy_r;
  logic recal_r;
  logic hit;
  logic [AW-1:0] last_wr;
  int wr_count;
  assign hit = mem_req && busy_r && !mem_ack;
  // ==========================================
  // Memory port
  // Read data is scrambled outside the ack cycle so a stale word never passes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      busy_r <= 1'b0;
      mem_rdata <= '0;
      mem_ce_lanes <= '0;
      mem_ue <= 1'b0;
      wr_count <= 0;
      last_wr <= '0;
    end else begin
      mem_ack <= hit;
      busy_r <= mem_req && !busy_r && !mem_ack;
      mem_rdata <= hit ? mem[mem_addr[3:0]] : ~mem_rdata;
      mem_ce_lanes <= (hit && !mem_we && mem_addr == inj_addr) ? inj_ce : '0;
      mem_ue <= hit && !mem_we && mem_addr == inj_addr && inj_ue;
      if (mem_ack && mem_we) begin
        wr_count <= wr_count + 1;
        last_wr <= mem_addr;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (mem_ack && mem_we) begin
      mem[mem_addr[3:0]] <= mem_wdata;
    end
  end
  // ==========================================
  // Recalibration, held back on demand to show the waiting phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recal_r <= 1'b0;
      recal_done <= 1'b0;
    end else begin
      recal_r <= recal_req;
      recal_done <= recal_req && recal_r && !hold_recal;
    end
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the scrubber and SEFI monitor
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst, ecc_en, init_start, init_use_addr, init_verify, scrub_en, recovery_en, drv_off_en;
  logic sefi_flag_clr, recal_done, mem_ack, mem_ue, mem_req, mem_we, init_busy, init_done, init_fail;
  logic recal_req, mode_rewrite_req, accel_active, scrub_pass_done, perm_sefi_irq, phy_err_irq, inj_ue, hold_recal;
  logic [63:0] init_pattern, mem_rdata, mem_wdata;
  logic [15:0] end_addr, scrub_period, mem_addr, inj_addr;
  logic [11:0] phy_lane_fail, mem_ce_lanes, sefi_seen, lane_drv_off, inj_ce;
  logic [23:0] lane_state;
  logic [71:0] lane_cnt;
  logic [5:0] watermark;
  logic [127:0] addr_err_cnt;
  int num_errors, check_count, n, base;
  scrub_sefi_error_monitor u_scrub_sefi_error_monitor (.core_clk, .rst, .ecc_en, .init_start, .init_use_addr,
    .init_verify, .init_pattern, .end_addr, .scrub_en, .scrub_period, .recovery_en, .drv_off_en, .sefi_flag_clr,
    .phy_lane_fail, .recal_done, .mem_ack, .mem_rdata, .mem_ce_lanes, .mem_ue, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .init_busy, .init_done, .init_fail, .recal_req, .mode_rewrite_req, .accel_active, .scrub_pass_done,
    .sefi_seen, .lane_state, .lane_drv_off, .perm_sefi_irq, .phy_err_irq, .lane_cnt, .watermark, .addr_err_cnt);
  mem_backend_model u_mem_backend_model (.core_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .recal_req,
    .inj_ce, .inj_ue, .inj_addr, .hold_recal, .mem_ack, .mem_rdata, .mem_ce_lanes, .mem_ue, .recal_done);
  // ==========================================
  // Common tasks
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_wr();
    base = u_mem_backend_model.wr_count;
    for (n = 0; n < 600 && u_mem_backend_model.wr_count == base; n++) cyc(1);
  endtask
  // ==========================================
  // Scenarios
  // Verify reads see injected errors too; counters must ignore them
  task automatic t_init(input logic use_addr, input logic verify, input logic bad);
    init_use_addr = use_addr;
    init_verify = verify;
    inj_ue = bad;
    init_start = 1'b1;
    cyc(1);
    init_start = 1'b0;
    for (n = 0; n < 300 && init_done !== 1'b1; n++) cyc(1);
    inj_ue = 1'b0;
    check({init_done, init_fail, init_busy}, {1'b1, bad & verify, 1'b0});
    check(lane_cnt[71:64], 8'h00);
    check(lane_cnt[63:0], 64'h0);
    for (int i = 0; i < 8; i++) check(u_mem_backend_model.mem[i], use_addr ? 64'(i) : init_pattern);
  endtask
  task automatic t_scrub();
    scrub_en = 1'b1;
    wait_wr();
    inj_ce = '0;
    cyc(4);
    check(u_mem_backend_model.last_wr, 16'h0005);
    check(u_mem_backend_model.mem[5], init_pattern);
    check({lane_cnt[23:18], watermark}, 12'h041);
    check(addr_err_cnt[15:0], 16'hff01);
    inj_ue = 1'b1;
    inj_ce = 12'hfff;
    base = u_mem_backend_model.wr_count;
    cyc(300);
    check(u_mem_backend_model.wr_count, base);
    check({lane_cnt[23:18], watermark}, 12'h041);
    inj_ue = 1'b0;
    inj_ce = '0;
    for (n = 0; n < 200 && scrub_pass_done !== 1'b1; n++) cyc(1);
    check(n < 200, 1'b1);
    cyc(1);
    check(scrub_pass_done, 1'b0);
  endtask
  // Lane 7 must run 64 errors ahead of the watermark before it fires
  task automatic t_passive();
    inj_addr = 16'h0002;
    inj_ce = 12'h080;
    for (int k = 1; k <= 64; k++) begin
      wait_wr();
      if (k == 63) begin
        cyc(4);
        check(sefi_seen, 12'h000);
      end
    end
    inj_ce = '0;
    cyc(4);
    check(sefi_seen, 12'h080);
    check({recal_req, lane_state}, 25'h0);
    check(addr_err_cnt[15:0], 16'h3fc1);
    sefi_flag_clr = 1'b1;
    cyc(1);
    sefi_flag_clr = 1'b0;
    check(sefi_seen, 12'h000);
  endtask
  task automatic t_recover(input logic perm);
    hold_recal = 1'b1;
    phy_lane_fail = 12'h002;
    for (n = 0; n < 8 && phy_err_irq !== 1'b1; n++) cyc(1);
    cyc(1);
    check({n < 8, phy_err_irq}, 2'b10);
    cyc(3);
    check({recal_req, mode_rewrite_req, lane_state[3:2]}, 4'hd);
    hold_recal = 1'b0;
    phy_lane_fail = '0;
    for (n = 0; n < 20 && accel_active !== 1'b1; n++) cyc(1);
    check({accel_active, recal_req}, 2'b10);
    for (n = 0; n < 600 && accel_active === 1'b1; n++) cyc(1);
    check(accel_active, 1'b0);
    if (perm) begin
      phy_lane_fail = 12'h002;
      for (n = 0; n < 20 && perm_sefi_irq !== 1'b1; n++) cyc(1);
      check(perm_sefi_irq, 1'b1);
      cyc(2);
      check({lane_state[3:2], lane_drv_off}, 14'h3002);
      phy_lane_fail = '0;
    end
    for (n = 0; n < 900 && lane_state[3:2] !== 2'h2; n++) cyc(1);
    check({lane_state[3:2], lane_drv_off}, 14'h2000);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    {ecc_en, init_verify, scrub_en, recovery_en, drv_off_en} = 5'b11000;
    {init_start, init_use_addr, sefi_flag_clr, inj_ue, hold_recal} = '0;
    phy_lane_fail = '0;
    inj_ce = 12'hfff;
    inj_addr = 16'h0005;
    init_pattern = 64'h5a5a_3c3c_a5a5_c3c3;
    end_addr = 16'h0007;
    scrub_period = 16'h0008;
    num_errors = 0;
    check_count = 0;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    ecc_en = 1'b0;
    init_start = 1'b1;
    cyc(2);
    check({init_busy, mem_req}, 2'b00);
    init_start = 1'b0;
    ecc_en = 1'b1;
    t_init(1'b1, 1'b1, 1'b0);
    t_init(1'b1, 1'b0, 1'b1);
    t_init(1'b0, 1'b1, 1'b1);
    t_scrub();
    t_passive();
    recovery_en = 1'b1;
    drv_off_en = 1'b1;
    t_recover(1'b0);
    t_recover(1'b1);
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
endmodule
